// ===== logic/line_monitor_readout.sv
// line_monitor_readout: read-only bank of line monitoring registers on an
// AHB-Lite slave, plus the extra bias control bit.
// assumes: the conversion path runs on ref_clk and pulses conv_done[ch]
// for one cycle while the matching code inputs hold the new result.
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - loop voltage register bit 6 is 0 for tip above ring, 1 below.
// - loop voltage bits 5:0 hold magnitude, 1.5 V per count, to 94.5 V.
// - loop current register bit 6 is 0 forward, 1 reverse.
// - loop current bits 5:0 hold magnitude, 1.25 mA per count.
// - tip voltage is an 8-bit code, 0x00 is 0 V, 0xff is -95.88 V.
// - ring voltage uses the same 8-bit scale, 0.376 V per count.
// - two battery voltage readings share that 8-bit scale.
// - transistor 1 and 2 currents: 8-bit, 0.319 mA per count.
// - with extra bias enabled, bias current is removed from those two.
// - transistor 3 and 4 currents: 8-bit, full scale 9.59 mA.
module line_monitor_readout
	import line_monitor_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [DATA_W-1:0] hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic      [DATA_W-1:0] hrdata,
	// conversion path
	input  wire logic              loop_volt_sign,
	input  wire logic [MAG_W-1:0]  loop_volt_magnitude,
	input  wire logic              loop_curr_sign,
	input  wire logic [MAG_W-1:0]  loop_curr_magnitude,
	input  wire logic [CODE_W-1:0] tip_node_voltage,
	input  wire logic [CODE_W-1:0] ring_node_voltage,
	input  wire logic [CODE_W-1:0] battery_volt_reading_a,
	input  wire logic [CODE_W-1:0] battery_volt_reading_b,
	input  wire logic [CODE_W-1:0] transistor1_current,
	input  wire logic [CODE_W-1:0] transistor2_current,
	input  wire logic [CODE_W-1:0] transistor3_current,
	input  wire logic [CODE_W-1:0] transistor4_current,
	input  wire logic [CODE_W-1:0] extra_bias_current,
	input  wire logic [NUM_SENSE-1:0] conv_done,
	// to the line drive logic
	output logic                   extra_bias_enable
);

	////////////////////////////////////////////////////////////////////////
	// saturating subtract, clamps at zero instead of wrapping
	function automatic logic [CODE_W-1:0] sub_sat(
		input logic [CODE_W-1:0] a,
		input logic [CODE_W-1:0] b
	);
		logic [CODE_W:0] diff;
		diff = {1'b0, a} - {1'b0, b};
		if (diff[CODE_W]) begin
			sub_sat = '0;
		end else begin
			sub_sat = diff[CODE_W-1:0];
		end
	endfunction : sub_sat

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic              bias_en_reg;
	logic              bias_en_next;
	bus_phase_t        phase_reg;
	bus_phase_t        phase_next;
	logic              wr_bias_reg;
	logic              wr_bias_next;
	logic [DATA_W-1:0] hrdata_reg;
	logic [DATA_W-1:0] hrdata_next;

	logic [CODE_W-1:0]    raw_code   [NUM_SENSE];
	logic [CODE_W-1:0]    sense_code [NUM_SENSE];
	logic [NUM_SENSE-1:0] seen_flag;

	logic [CODE_W-1:0] t1_net;
	logic [CODE_W-1:0] t2_net;

	logic              addr_phase;
	logic              size_ok;
	logic              aligned;
	logic [IDX_W-1:0]  addr_idx;
	logic              hit_sense;
	logic              hit_bias;
	logic              hit_status;
	logic [IDX_W-1:0]  sense_ofs;
	logic [CH_W-1:0]   sense_ch;
	logic              wr_commit;
	logic              bias_now;
	logic [DATA_W-1:0] sense_word;
	logic [DATA_W-1:0] bias_word;
	logic [DATA_W-1:0] status_word;
	logic [DATA_W-1:0] read_word;

	////////////////////////////////////////////////////////////////////////
	// packing of the conversion results into register codes

	// loop voltage: reserved bit 7 zero, polarity bit 6, magnitude 5:0
	assign raw_code[CH_LOOP_VOLT] = {
		RESERVED_ZERO,
		loop_volt_sign,
		loop_volt_magnitude
	};

	// loop current: reserved bit 7 zero, direction bit 6, magnitude 5:0
	assign raw_code[CH_LOOP_CURR] = {
		RESERVED_ZERO,
		loop_curr_sign,
		loop_curr_magnitude
	};

	// node voltages pass through on the 0.376 V per count scale
	assign raw_code[CH_TIP_VOLT]    = tip_node_voltage;
	assign raw_code[CH_RING_VOLT]   = ring_node_voltage;
	assign raw_code[CH_BATT_VOLT_A] = battery_volt_reading_a;
	assign raw_code[CH_BATT_VOLT_B] = battery_volt_reading_b;

	// transistor 1 and 2 without the added bias current when it is on
	assign t1_net = sub_sat(transistor1_current, extra_bias_current);
	assign t2_net = sub_sat(transistor2_current, extra_bias_current);

	// bias removal follows the enable bit that the drive logic sees
	assign raw_code[CH_TRANSISTOR1] = bias_en_reg ? t1_net
		: transistor1_current;
	assign raw_code[CH_TRANSISTOR2] = bias_en_reg ? t2_net
		: transistor2_current;

	// transistor 3 and 4 on the fine scale, passed as they come
	assign raw_code[CH_TRANSISTOR3] = transistor3_current;
	assign raw_code[CH_TRANSISTOR4] = transistor4_current;

	////////////////////////////////////////////////////////////////////////
	// one capture register per channel, loaded only by the conversion path

	generate
		for (genvar g = 0; g < NUM_SENSE; g++) begin : g_cap
			sense_capture #(
				.W     (CODE_W),
				.RESET (SENSE_RESET)
			) u_cap (
				.ref_clk  (ref_clk),
				.rst      (rst),
				.load     (conv_done[g]),
				.code_in  (raw_code[g]),
				.code_out (sense_code[g]),
				.seen     (seen_flag[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// address phase decode

	// a transfer is taken when selected, bus ready and NONSEQ or SEQ
	assign addr_phase = hsel & hready & htrans[1];
	assign size_ok    = (hsize == HSIZE_WORD);
	assign aligned    = (haddr[WORD_SHIFT-1:0] == BYTE_ALIGNED);
	assign addr_idx   = haddr[ADDR_W-1:WORD_SHIFT];

	// the sense indices are contiguous, so the channel is an offset
	assign hit_sense  = aligned
		& (addr_idx >= IDX_LOOP_VOLT)
		& (addr_idx <= IDX_TRANSISTOR4);
	assign hit_bias   = aligned & (addr_idx == IDX_BIAS_CONTROL);
	assign hit_status = aligned & (addr_idx == IDX_SENSE_STATUS);
	assign sense_ofs  = addr_idx - IDX_LOOP_VOLT;
	assign sense_ch   = sense_ofs[CH_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// read data selection

	// a write to the bias bit still in its data phase is forwarded, so a
	// read right behind it sees the new value
	assign wr_commit = (phase_reg == PH_WRITE) & wr_bias_reg;
	assign bias_now  = wr_commit ? hwdata[BIAS_EN_BIT] : bias_en_reg;

	// narrow codes sit in the low bits, upper bits read zero
	assign sense_word  = {{(DATA_W-CODE_W){1'b0}}, sense_code[sense_ch]};
	assign bias_word   = {{(DATA_W-1){1'b0}}, bias_now};
	assign status_word = {{(DATA_W-NUM_SENSE){1'b0}}, seen_flag};

	// unmapped addresses read as zero
	assign read_word = hit_sense  ? sense_word
		: hit_bias   ? bias_word
		: hit_status ? status_word
		: READ_ZERO;

	////////////////////////////////////////////////////////////////////////
	// next state of the bus slave

	// data phase kind; with zero wait states it lasts one cycle
	assign phase_next = !addr_phase ? PH_IDLE
		: hwrite ? PH_WRITE
		: PH_READ;

	// only a whole-word write to the bias control is remembered; writes
	// to the monitoring registers are dropped here
	assign wr_bias_next = addr_phase & hwrite & size_ok
		& hit_bias;

	// read data captured at the end of the address phase
	assign hrdata_next = (addr_phase & !hwrite) ? read_word : hrdata_reg;

	// bias bit takes the write data in its data phase
	assign bias_en_next = wr_commit ? hwdata[BIAS_EN_BIT] : bias_en_reg;

	////////////////////////////////////////////////////////////////////////
	// bus slave registers

	// data phase tracking
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_reg   <= PH_IDLE;
			wr_bias_reg <= 1'b0;
		end else begin
			phase_reg   <= phase_next;
			wr_bias_reg <= wr_bias_next;
		end
	end

	// read data holding register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hrdata_reg <= READ_ZERO;
		end else begin
			hrdata_reg <= hrdata_next;
		end
	end

	// extra bias enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bias_en_reg <= BIAS_EN_RESET;
		end else begin
			bias_en_reg <= bias_en_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// never stalls, always answers OKAY
	assign hreadyout         = 1'b1;
	assign hresp             = HRESP_OKAY;
	assign hrdata            = hrdata_reg;
	assign extra_bias_enable = bias_en_reg;

endmodule : line_monitor_readout

// ===== logic/line_monitor_pkg.sv
// line_monitor_pkg: shared constants for the line monitor readout block.
// assumes: AHB-Lite with 32-bit data, one aligned word per register, and
// byte address equal to four times the register index.

package line_monitor_pkg;

	// bus shape
	localparam int DATA_W     = 32;
	localparam int ADDR_W     = 12;
	localparam int WORD_SHIFT = 2;
	localparam int IDX_W      = ADDR_W - WORD_SHIFT;

	// code shapes
	localparam int CODE_W    = 8;
	localparam int MAG_W     = 6;
	localparam int SIGN_BIT  = 6;
	localparam int NUM_SENSE = 10;
	localparam int CH_W      = 4;

	// register indices (byte address = index * 4)
	localparam logic [IDX_W-1:0] IDX_LOOP_VOLT     = 10'h04e;
	localparam logic [IDX_W-1:0] IDX_LOOP_CURR     = 10'h04f;
	localparam logic [IDX_W-1:0] IDX_TIP_VOLT      = 10'h050;
	localparam logic [IDX_W-1:0] IDX_RING_VOLT     = 10'h051;
	localparam logic [IDX_W-1:0] IDX_BATT_VOLT_A   = 10'h052;
	localparam logic [IDX_W-1:0] IDX_BATT_VOLT_B   = 10'h053;
	localparam logic [IDX_W-1:0] IDX_TRANSISTOR1   = 10'h054;
	localparam logic [IDX_W-1:0] IDX_TRANSISTOR2   = 10'h055;
	localparam logic [IDX_W-1:0] IDX_TRANSISTOR3   = 10'h056;
	localparam logic [IDX_W-1:0] IDX_TRANSISTOR4   = 10'h057;
	localparam logic [IDX_W-1:0] IDX_BIAS_CONTROL  = 10'h058;
	localparam logic [IDX_W-1:0] IDX_SENSE_STATUS  = 10'h059;

	// capture channels, in the same order as the register indices
	localparam int CH_LOOP_VOLT   = 0;
	localparam int CH_LOOP_CURR   = 1;
	localparam int CH_TIP_VOLT    = 2;
	localparam int CH_RING_VOLT   = 3;
	localparam int CH_BATT_VOLT_A = 4;
	localparam int CH_BATT_VOLT_B = 5;
	localparam int CH_TRANSISTOR1 = 6;
	localparam int CH_TRANSISTOR2 = 7;
	localparam int CH_TRANSISTOR3 = 8;
	localparam int CH_TRANSISTOR4 = 9;

	// reset values and fields
	localparam logic [CODE_W-1:0] SENSE_RESET     = 8'h00;
	localparam logic              RESERVED_ZERO   = 1'b0;
	localparam int                BIAS_EN_BIT     = 0;
	localparam logic              BIAS_EN_RESET   = 1'b0;
	localparam logic [DATA_W-1:0] READ_ZERO       = 32'h0000_0000;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic       HRESP_OKAY    = 1'b0;
	localparam logic [1:0] BYTE_ALIGNED  = 2'h0;

	// data phase tracking, one-hot
	typedef enum logic [2:0] {
		PH_IDLE  = 3'b001,
		PH_READ  = 3'b010,
		PH_WRITE = 3'b100
	} bus_phase_t;

endpackage : line_monitor_pkg

// ===== logic/sense_capture.sv
// sense_capture: one monitoring code held in a register, refreshed on a
// conversion strobe, with a flag that shows it has been loaded since reset.
// assumes: load and code_in come from logic on the same clock.
`timescale 1ns/1ps

module sense_capture #(
	parameter int          W     = 8,
	parameter logic [W-1:0] RESET = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] code_in,
	output logic      [W-1:0] code_out,
	output logic              seen
);

	////////////////////////////////////////////////////////////////////////
	// latest completed conversion, no request handshake
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			code_out <= RESET;
		end else if (load) begin
			code_out <= code_in;
		end
	end

	// sticky once the first conversion has arrived
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			seen <= 1'b0;
		end else if (load) begin
			seen <= 1'b1;
		end
	end

endmodule : sense_capture

// ===== testbench/line_monitor_readout_monitor.sv
// line_monitor_readout_monitor: bus and capture checks for the bank.
// assumes: zero-wait slave, conv_done pulses with its code held valid.
`timescale 1ns/1ps

module line_monitor_checker
	import line_monitor_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst,
	input wire logic              hsel,
	input wire logic [ADDR_W-1:0] haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [2:0]        hsize,
	input wire logic [DATA_W-1:0] hwdata,
	input wire logic              hready,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic [DATA_W-1:0] hrdata,
	input wire logic              loop_volt_sign,
	input wire logic [MAG_W-1:0]  loop_volt_magnitude,
	input wire logic              loop_curr_sign,
	input wire logic [MAG_W-1:0]  loop_curr_magnitude,
	input wire logic [CODE_W-1:0] tip_node_voltage,
	input wire logic [CODE_W-1:0] transistor1_current,
	input wire logic [CODE_W-1:0] extra_bias_current,
	input wire logic [NUM_SENSE-1:0] conv_done,
	input wire logic              extra_bias_enable
);
	////////////////////////////////////////
	// address phase decodes and expected codes
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic       rd_at = hsel && hready && htrans[1] && !hwrite;
	wire logic       rd_sense = rd_at && haddr >= 12'h138 && haddr <= 12'h15c;
	wire logic       wr_bias = hsel && hready && htrans[1] && hwrite &&
		hsize == HSIZE_WORD && haddr == 12'h160;
	wire logic [6:0] loop_code = {loop_volt_sign, loop_volt_magnitude};
	wire logic [6:0] curr_code = {loop_curr_sign, loop_curr_magnitude};
	wire logic [7:0] t1_sub = transistor1_current - extra_bias_current;
	wire logic [7:0] t1_exp = !extra_bias_enable ? transistor1_current :
		(transistor1_current > extra_bias_current) ? t1_sub : 8'h00;

	////////////////////////////////////////
	// properties
	AST_READY_OKAY: assert property (
		hreadyout && hresp == HRESP_OKAY)
		else $error("slave stalled or not okay");
	AST_SENSE_HIGH_ZERO: assert property (
		rd_sense |=> hrdata[31:8] == 24'h0)
		else $error("sense read upper bits set");
	AST_LOOP_RESERVED: assert property (
		rd_at && haddr[11:3] == 9'h027 |=> !hrdata[7])
		else $error("loop register bit 7 set");
	AST_LOOP_VOLT: assert property (
		conv_done[CH_LOOP_VOLT] ##1 (rd_at && haddr == 12'h138)
		|=> hrdata[6:0] == $past(loop_code, 2))
		else $error("loop voltage read wrong");
	AST_LOOP_CURR: assert property (
		conv_done[CH_LOOP_CURR] ##1 (rd_at && haddr == 12'h13c)
		|=> hrdata[6:0] == $past(curr_code, 2))
		else $error("loop current read wrong");
	AST_TIP_CODE: assert property (
		conv_done[CH_TIP_VOLT] ##1 (rd_at && haddr == 12'h140)
		|=> hrdata[7:0] == $past(tip_node_voltage, 2))
		else $error("tip voltage read wrong");
	AST_T1_BIAS: assert property (
		conv_done[CH_TRANSISTOR1] ##1 (rd_at && haddr == 12'h150)
		|=> hrdata[7:0] == $past(t1_exp, 2))
		else $error("transistor 1 read wrong");
	AST_BIAS_WRITE: assert property (
		wr_bias ##1 1'b1 |=> extra_bias_enable == $past(hwdata[0]))
		else $error("bias enable not written");
	AST_BIAS_HOLD: assert property (
		$changed(extra_bias_enable) |-> $past(wr_bias, 2))
		else $error("bias enable changed alone");
	AST_UNMAPPED_ZERO: assert property (
		rd_at && haddr > 12'h164 |=> hrdata == READ_ZERO)
		else $error("unmapped read not zero");
	AST_RDATA_HOLD: assert property (
		!rd_at |=> $stable(hrdata))
		else $error("read data moved without a read");
	cover property (conv_done[CH_TIP_VOLT] ##1 (rd_at && haddr == 12'h140));
	cover property (wr_bias);
	cover property (conv_done[CH_TRANSISTOR1] && extra_bias_enable);
endmodule : line_monitor_checker

bind line_monitor_readout line_monitor_checker line_monitor_checker_inst (
	.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready, .hreadyout, .hresp, .hrdata, .loop_volt_sign,
	.loop_volt_magnitude, .loop_curr_sign, .loop_curr_magnitude,
	.tip_node_voltage, .transistor1_current,
	.extra_bias_current, .conv_done, .extra_bias_enable
);

// ===== testbench/conv_model.sv
// conv_model: conversion path that loads one channel code after a lag.
// assumes: start is honoured only while busy is low.
`timescale 1ns/1ps

module conv_model
	import line_monitor_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        start,
	input  wire logic [3:0]  ch,
	input  wire logic [7:0]  val,
	input  wire logic [1:0]  lag,
	output logic [NUM_SENSE-1:0]             done,
	output logic [NUM_SENSE-1:0][CODE_W-1:0] codes,
	output logic             busy
);
	logic [1:0] wait_reg;
	logic [3:0] ch_reg;
	logic [7:0] val_reg;

	// code lines toggle outside their strobe, so stale data never matches
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			done <= '0;
			codes <= '1;
			wait_reg <= 2'h0;
		end else begin
			done <= '0;
			codes <= ~codes;
			if (start && !busy) begin
				busy <= 1'b1;
				ch_reg <= ch;
				val_reg <= val;
				wait_reg <= lag;
			end else if (busy && wait_reg != 2'h0) begin
				wait_reg <= wait_reg - 2'h1;
			end else if (busy) begin
				busy <= 1'b0;
				done[ch_reg] <= 1'b1;
				codes[ch_reg] <= val_reg;
			end
		end
	end
endmodule : conv_model

// ===== testbench/tb_line_monitor_readout.sv
// tb_line_monitor_readout: self-checking bench for the readout bank.
// assumes: one AHB-Lite slave, hready fed from hreadyout, 20 MHz clock.
`timescale 1ns/1ps

module tb_line_monitor_readout
	import line_monitor_pkg::*;
;
	logic                     ref_clk, rst = 1'b1, hsel = 1'b0, busy, ebe;
	logic                     hwrite = 1'b0, start = 1'b0, en = 1'b0;
	logic                     hreadyout, hresp, rd_ph;
	logic [ADDR_W-1:0]        haddr = '0;
	logic [1:0]               htrans = 2'h0, lag = 2'h0;
	logic [2:0]               hsize = HSIZE_WORD;
	logic [DATA_W-1:0]        hwdata = '0, hrdata;
	logic [CODE_W-1:0]        bias_cur = '0, val = '0, v;
	logic [3:0]               ch = '0;
	logic [NUM_SENSE-1:0]     done;
	logic [NUM_SENSE-1:0][7:0] codes;
	logic [DATA_W-1:0]        last [NUM_SENSE];
	logic [CODE_W-1:0]        tbl [4] = '{8'h00, 8'hff, 8'h40, 8'hbf};
	logic [DATA_W-1:0]        exp_q [$];
	int                       n_fail = 0, cmp_count = 0, seed = 32'h17e12d13;

	////////////////////////////////////////
	// clock, design and conversion path
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	line_monitor_readout line_monitor_readout_inst (
		.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.loop_volt_sign(codes[0][6]), .loop_volt_magnitude(codes[0][5:0]),
		.loop_curr_sign(codes[1][6]), .loop_curr_magnitude(codes[1][5:0]),
		.tip_node_voltage(codes[2]), .ring_node_voltage(codes[3]),
		.battery_volt_reading_a(codes[4]), .battery_volt_reading_b(codes[5]),
		.transistor1_current(codes[6]), .transistor2_current(codes[7]),
		.transistor3_current(codes[8]), .transistor4_current(codes[9]),
		.extra_bias_current(bias_cur), .conv_done(done),
		.extra_bias_enable(ebe)
	);
	conv_model conv_model_inst (
		.ref_clk, .rst, .start, .ch, .val, .lag, .done, .codes, .busy
	);

	////////////////////////////////////////
	// helpers
	function automatic logic [ADDR_W-1:0] sa(input int c);
		return {IDX_LOOP_VOLT + IDX_W'(c), BYTE_ALIGNED};
	endfunction : sa
	// expected word: loop codes drop bit 7, bias leaves transistors 1 and 2
	function automatic logic [DATA_W-1:0] ex(input int c, input logic [7:0] d);
		if (c < 2)
			return {24'h0, d & 8'h7f};
		if (en && (c == 6 || c == 7))
			return (d > bias_cur) ? {24'h0, d - bias_cur} : READ_ZERO;
		return {24'h0, d};
	endfunction : ex
	task automatic cmp(input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		cmp_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask : cmp
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
	endtask : bus
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, $random(seed));
	endtask : rd
	task automatic conv(input int c, input logic [CODE_W-1:0] d);
		@(posedge ref_clk);
		start <= 1'b1;
		ch <= 4'(c);
		val <= d;
		lag <= 2'($random(seed));
		@(posedge ref_clk);
		start <= 1'b0;
		do @(negedge ref_clk); while (busy === 1'b1);
	endtask : conv
	task automatic chk_reset();
		for (int i = 0; i < 12; i++)
			rd(sa(i), READ_ZERO);
	endtask : chk_reset
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// watcher: each read data phase takes the oldest expectation
	always @(posedge ref_clk) begin
		if (rd_ph === 1'b1)
			cmp(exp_q.pop_front(), hrdata);
		rd_ph <= hsel && hreadyout && htrans[1] && !hwrite && !rst;
	end
	// watchdog, far beyond the several hundred cycles the run needs
	initial begin
		#(50 * 20000);
		n_fail++;
		results();
	end

	////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		chk_reset();
		for (int k = 0; k < 5; k++) begin
			for (int c = 0; c < NUM_SENSE; c++) begin
				v = (k < 4) ? tbl[k] : 8'($random(seed));
				conv(c, v);
				last[c] = ex(c, v);
				rd(sa(c), last[c]);
			end
		end
		rd(sa(11), 32'h0000_03ff);
		for (int c = 0; c < NUM_SENSE; c++) begin
			bus(1'b1, sa(c), ~last[c]);
			rd(sa(c), last[c]);
		end
		rd(12'h200, READ_ZERO);
		bias_cur <= 8'h30;
		for (int b = 1; b >= 0; b--) begin
			en = b[0];
			bus(1'b1, sa(10), {31'h0, en});
			rd(sa(10), {31'h0, en});
			for (int c = 6; c < NUM_SENSE; c++) begin
				for (int k = 0; k < 3; k++) begin
					v = (k == 0) ? 8'h20 : (k == 1) ? 8'h30 : 8'hc5;
					conv(c, v);
					rd(sa(c), ex(c, v));
				end
			end
		end
		// byte-sized and unaligned writes must leave the bias bit alone
		hsize <= 3'h0;
		bus(1'b1, sa(10), 32'h1);
		hsize <= HSIZE_WORD;
		bus(1'b1, sa(10) + 12'h2, 32'h1);
		rd(sa(10), READ_ZERO);
		rd(sa(2) + 12'h1, READ_ZERO);
		bus(1'b1, sa(10), 32'h1);
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		chk_reset();
		// let the watcher take the last read before the verdict
		repeat (2) @(posedge ref_clk);
		cmp(READ_ZERO, exp_q.size());
		results();
	end
endmodule : tb_line_monitor_readout
